// ---- dv/e1_rx_interworking_aux_irq_test.sv ----
`timescale 1ns/1ps
`default_nettype none

// Counts every comparison and reports a mismatch at once.
`define CHECK_EQ(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module e1_rx_interworking_aux_irq_test;
  import e1_rx_irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Short search time keeps the interworking scenario brief.
  localparam int unsigned IwCyc = 20;
  localparam logic [ADDR_W-1:0] UNMAPPED_OFF = 16'h0b0c;

  logic clk;
  logic rst;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic regWr;
  logic regRd;
  logic [DATA_W-1:0] regRdData;
  logic basicFrameAligned;
  logic crc4MfAligned;
  logic altPatternDetected;
  logic interworkingState;
  logic irq;
  int n_errors;
  int checks_done;

  e1_rx_interworking_aux_irq #(
    .IwTimeoutCyc(IwCyc)
  ) dut_u (
    .clk(clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .basicFrameAligned(basicFrameAligned),
    .crc4MfAligned(crc4MfAligned),
    .altPatternDetected(altPatternDetected),
    .interworkingState(interworkingState),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock at 100 ns period.
  always #50 clk = ~clk;

  // One-cycle write strobe beside address and data.
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHECK_EQ(regRdData, exp)
  endtask

  // Lets a number of whole clock cycles pass, then settles past the edge.
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short well beyond the expected 121 or so cycles.
  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // Main sequence of register accesses and framer level changes.
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    basicFrameAligned = 1'b0;
    crc4MfAligned = 1'b0;
    altPatternDetected = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values, enable register mask and an unmapped place.
    rd_check(STATUS_OFF, 8'h00);
    rd_check(ENABLE_OFF, 8'h00);
    rd_check(CTRL_OFF, 8'h00);
    rd_check(UNMAPPED_OFF, 8'h00);
    wr_reg(ENABLE_OFF, 8'hff);
    rd_check(ENABLE_OFF, ENABLE_MASK);
    wr_reg(UNMAPPED_OFF, 8'hff);
    rd_check(UNMAPPED_OFF, 8'h00);
    // Pattern start with its enable off: flag set, no interrupt.
    wr_reg(ENABLE_OFF, 8'h00);
    altPatternDetected <= 1'b1;
    idle(3);
    `CHECK_EQ(irq, 1'b0)
    rd_check(STATUS_OFF, 8'hc0);
    rd_check(STATUS_OFF, 8'h80);
    // Pattern end with its enable on: interrupt until the status read.
    wr_reg(ENABLE_OFF, 8'h50);
    altPatternDetected <= 1'b0;
    idle(3);
    `CHECK_EQ(irq, 1'b1)
    rd_check(STATUS_OFF, 8'h40);
    idle(2);
    `CHECK_EQ(irq, 1'b0)
    // Basic framing without multiframe: interworking declared after exactly the search time.
    @(posedge clk);
    basicFrameAligned <= 1'b1;
    wr_reg(CTRL_OFF, 8'h01);
    idle(IwCyc);
    `CHECK_EQ(interworkingState, 1'b0)
    idle(1);
    `CHECK_EQ(interworkingState, 1'b1)
    idle(2);
    `CHECK_EQ(irq, 1'b1)
    // A write to the status register clears the change flag too.
    wr_reg(STATUS_OFF, 8'h00);
    rd_check(STATUS_OFF, 8'h20);
    // Multiframe found: back to normal operation, reported as a change.
    @(posedge clk);
    crc4MfAligned <= 1'b1;
    idle(3);
    `CHECK_EQ(interworkingState, 1'b0)
    rd_check(STATUS_OFF, 8'h10);
    // Second entry with only the pattern enable set stays silent.
    wr_reg(ENABLE_OFF, 8'h40);
    crc4MfAligned <= 1'b0;
    idle(IwCyc + 10);
    `CHECK_EQ(irq, 1'b0)
    rd_check(STATUS_OFF, 8'h30);
    // Algorithm switched off: declared interworking is dropped and reported as a change.
    wr_reg(CTRL_OFF, 8'h00);
    idle(3);
    `CHECK_EQ(interworkingState, 1'b0)
    rd_check(STATUS_OFF, 8'h10);
    complete_run();
  end
endmodule

`default_nettype wire

// ---- hdl/e1_rx_interworking_aux_irq.sv ----
// Functional notes
// - Interworking change flag sits at status bit 4, cleared by register read or write.
// - Entering non-CRC-4 interworking raises the interworking change event.
// - Leaving interworking back to CRC-4 operation also raises the event.
// - Enable bit 4, reset 0, gates the interworking change interrupt.
// - Enable bit 6, reset 0, gates the alternating pattern change interrupt.
// - Start and end of alternating pattern detection both raise an event.
// - With algorithm on, no multiframe in 400 ms with basic framing declares interworking.
// - Status bit 7 shows live alternating pattern detection; its changes are events.
`timescale 1ns/1ps
`default_nettype none

module e1_rx_interworking_aux_irq #(
  parameter int unsigned IwTimeoutCyc = 32'(e1_rx_irq_pkg::IW_TIMEOUT_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [e1_rx_irq_pkg::ADDR_W-1:0] regAddr,
  input wire logic [e1_rx_irq_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [e1_rx_irq_pkg::DATA_W-1:0] regRdData,
  input wire logic basicFrameAligned,
  input wire logic crc4MfAligned,
  input wire logic altPatternDetected,
  output logic interworkingState,
  output logic irq
);

  import e1_rx_irq_pkg::*;

  localparam logic [IW_CNT_W-1:0] IwLast = IW_CNT_W'(IwTimeoutCyc - 1);

  iw_state_e iwState_r;
  iw_state_e iwState_nxt;
  logic [IW_CNT_W-1:0] iwCnt_r;
  logic iwLevel_r;
  logic algoEn_r;
  logic [DATA_W-1:0] enable_r;
  logic iwFlag_r;
  logic altFlag_r;
  logic [DATA_W-1:0] rdData_r;
  logic irq_r;
  wire logic [NUM_EVENTS-1:0] levels;
  wire logic [NUM_EVENTS-1:0] changes;
  logic statusAccess;
  logic searching;

  // Decodes a strobe aimed at one register offset.
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  assign statusAccess = (regRd | regWr) & hit(regAddr, STATUS_OFF);
  assign searching = basicFrameAligned & ~crc4MfAligned;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Interworking search.

  // Chooses the next search state from alignment and the elapsed count.
  always_comb
  begin
    iwState_nxt = iwState_r;
    case (iwState_r)
      IW_OFF:
      begin
        if (algoEn_r)
        begin
          iwState_nxt = IW_WAIT;
        end
      end
      IW_WAIT:
      begin
        if (!algoEn_r)
        begin
          iwState_nxt = IW_OFF;
        end
        else if (searching && (iwCnt_r == IwLast))
        begin
          iwState_nxt = IW_NONCRC;
        end
      end
      IW_NONCRC:
      begin
        if (!algoEn_r)
        begin
          iwState_nxt = IW_OFF;
        end
        else if (crc4MfAligned)
        begin
          iwState_nxt = IW_WAIT;
        end
      end
      default:
      begin
        iwState_nxt = IW_OFF;
      end
    endcase
  end

  // Holds the search state.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      iwState_r <= IW_OFF;
    end
    else
    begin
      iwState_r <= iwState_nxt;
    end
  end

  // Counts cycles of basic framing without multiframe; any break restarts the wait.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      iwCnt_r <= '0;
    end
    else if ((iwState_r == IW_WAIT) && searching && (iwCnt_r != IwLast))
    begin
      iwCnt_r <= iwCnt_r + 1'b1;
    end
    else if (iwState_r != IW_WAIT || !searching)
    begin
      iwCnt_r <= '0;
    end
  end

  // Level seen by software and by the change detector.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      iwLevel_r <= 1'b0;
    end
    else
    begin
      iwLevel_r <= (iwState_nxt == IW_NONCRC);
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Change detection.

  assign levels[EV_IW] = iwLevel_r;
  assign levels[EV_ALT] = altPatternDetected;

  // One detector per watched level.
  for (genvar i = 0; i < NUM_EVENTS; i++)
  begin : g_change
    level_change_detect u_detect (
      .clk(clk),
      .rst(rst),
      .level(levels[i]),
      .changed(changes[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a new event in the clearing cycle keeps the flag set.

  // Interworking change flag.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      iwFlag_r <= FLAG_RST;
    end
    else
    begin
      iwFlag_r <= (iwFlag_r & ~statusAccess) | changes[EV_IW];
    end
  end

  // Alternating pattern change flag.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      altFlag_r <= FLAG_RST;
    end
    else
    begin
      altFlag_r <= (altFlag_r & ~statusAccess) | changes[EV_ALT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Writable registers.

  // Enable register keeps only its two defined bits.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      enable_r <= ENABLE_RST;
    end
    else if (regWr && hit(regAddr, ENABLE_OFF))
    begin
      enable_r <= regWrData & ENABLE_MASK;
    end
  end

  // Control register holds the algorithm enable.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      algoEn_r <= CTRL_RST;
    end
    else if (regWr && hit(regAddr, CTRL_OFF))
    begin
      algoEn_r <= regWrData[ALGO_EN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Read path and interrupt.

  // Read data stand one cycle after the strobe and are zero otherwise.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdData_r <= '0;
    end
    else
    begin
      rdData_r <= '0;
      if (regRd && hit(regAddr, STATUS_OFF))
      begin
        rdData_r[ALT_PRESENT_BIT] <= altPatternDetected;
        rdData_r[ALT_FLAG_BIT] <= altFlag_r;
        rdData_r[IW_STATE_BIT] <= iwLevel_r;
        rdData_r[IW_FLAG_BIT] <= iwFlag_r;
      end
      else if (regRd && hit(regAddr, ENABLE_OFF))
      begin
        rdData_r <= enable_r;
      end
      else if (regRd && hit(regAddr, CTRL_OFF))
      begin
        rdData_r[ALGO_EN_BIT] <= algoEn_r;
      end
    end
  end

  // Interrupt level follows the enabled flags one cycle later.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= (iwFlag_r & enable_r[IW_EN_BIT]) | (altFlag_r & enable_r[ALT_EN_BIT]);
    end
  end

  assign regRdData = rdData_r;
  assign interworkingState = iwLevel_r;
  assign irq = irq_r;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  flag_clear_a: assert property (
    statusAccess && !changes[EV_IW] |=> !iwFlag_r)
    else $error("Interworking flag not cleared by status access.");

  iw_enter_a: assert property (
    $rose(iwLevel_r) |=> iwFlag_r)
    else $error("Entering interworking did not set the flag.");

  iw_leave_a: assert property (
    $fell(iwLevel_r) |=> iwFlag_r)
    else $error("Leaving interworking did not set the flag.");

  iw_gate_a: assert property (
    !enable_r[IW_EN_BIT] && !(altFlag_r && enable_r[ALT_EN_BIT]) |=> !irq_r)
    else $error("Interrupt raised with interworking enable off.");

  alt_gate_a: assert property (
    altFlag_r && enable_r[ALT_EN_BIT] |=> irq_r)
    else $error("Enabled pattern flag did not raise interrupt.");

  alt_event_a: assert property (
    $changed(altPatternDetected) |=> altFlag_r[*2] or (altFlag_r ##1 !altFlag_r))
    else $error("Pattern change did not set the flag.");

  reserved_zero_a: assert property (
    regRd && (hit(regAddr, ENABLE_OFF) || hit(regAddr, STATUS_OFF))
    |=> (regRdData[5] == 1'b0 || hit($past(regAddr), STATUS_OFF)) && regRdData[3:0] == 4'h0)
    else $error("Reserved bits read nonzero.");

  iw_declare_a: assert property (
    $rose(iwLevel_r) |-> $past(algoEn_r) && $past(basicFrameAligned) && !$past(crc4MfAligned)
    && $past(iwCnt_r) == IwLast)
    else $error("Interworking declared without full wait.");

  alt_live_a: assert property (
    regRd && hit(regAddr, STATUS_OFF) |=> regRdData[ALT_PRESENT_BIT] == $past(altPatternDetected))
    else $error("Pattern level misreported.");

  rd_idle_a: assert property (
    !regRd |=> regRdData == 8'h00)
    else $error("Read data not zero outside a read.");

  iw_declared_c: cover property ($rose(iwLevel_r));
  irq_raised_c: cover property ($rose(irq_r));
  clear_race_c: cover property (statusAccess && changes[EV_ALT]);
  alt_flag_read_c: cover property (regRd && hit(regAddr, STATUS_OFF) && altFlag_r);

endmodule
`default_nettype wire

// ---- hdl/e1_rx_irq_pkg.sv ----
// Shared constants for the receive interworking and alternating-pattern interrupt logic.
package e1_rx_irq_pkg;

  // Register port widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [ADDR_W-1:0] STATUS_OFF = 16'h0b0a;
  localparam logic [ADDR_W-1:0] ENABLE_OFF = 16'h0b0b;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 16'h0b0f;

  // Status register field positions.
  localparam int ALT_PRESENT_BIT = 7;
  localparam int ALT_FLAG_BIT = 6;
  localparam int IW_STATE_BIT = 5;
  localparam int IW_FLAG_BIT = 4;

  // Enable register field positions, same layout as the flags.
  localparam int ALT_EN_BIT = 6;
  localparam int IW_EN_BIT = 4;

  // Control register field position.
  localparam int ALGO_EN_BIT = 0;

  // Reset values.
  localparam logic [DATA_W-1:0] ENABLE_RST = 8'h00;
  localparam logic CTRL_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;

  // Writable and readable bits of the enable register.
  localparam logic [DATA_W-1:0] ENABLE_MASK = 8'h50;

  // Interworking search timing.
  localparam longint unsigned CLK_FREQ_HZ = 64'd10000000;
  localparam longint unsigned IW_TIME_MS = 64'd400;
  localparam longint unsigned IW_TIMEOUT_CYC = (IW_TIME_MS * CLK_FREQ_HZ + 64'd999) / 64'd1000;
  localparam int IW_CNT_W = 22;

  // Number of level inputs watched for changes.
  localparam int NUM_EVENTS = 2;
  localparam int EV_IW = 0;
  localparam int EV_ALT = 1;

  // Interworking search states.
  typedef enum logic [1:0] {
    IW_OFF = 2'b00,
    IW_WAIT = 2'b01,
    IW_NONCRC = 2'b10
  } iw_state_e;

endpackage

// ---- hdl/level_change_detect.sv ----
`timescale 1ns/1ps
`default_nettype none

// Gives a one-cycle pulse in the cycle a level differs from its value one cycle earlier.
module level_change_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic changed
);

  logic level_r;

  // Remembers the level of the previous cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      level_r <= 1'b0;
    end
    else
    begin
      level_r <= level;
    end
  end

  // Both rising and falling transitions count.
  assign changed = level ^ level_r;

endmodule
`default_nettype wire
